// ---- cbt_bit_timing.sv ----
// cbt_bit_timing: CAN nominal bit timing with edge synchronisation
// assumes rx_i is the bus level synchronous to clk_i (1 = recessive)
// and a protocol engine that supplies tx_bit_i, transmitting_i, bus_idle_i
`timescale 1ns/1ps
module cbt_bit_timing #(
  parameter int PRESC_W = 6
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // axi4-lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // can bus side
  input  wire logic        rx_i,
  output logic             tx_o,
  // protocol engine side
  input  wire logic        tx_bit_i,
  input  wire logic        transmitting_i,
  input  wire logic        bus_idle_i,
  output logic             tx_point_o,
  output logic             bit_valid_o,
  output logic             bit_value_o
);

  generate
    if (PRESC_W != 6) begin : g_bad
      $error("cbt_bit_timing: prescaler field is 6 bits wide");
    end
  endgenerate

  // ---------------- register file ----------------
  logic [cbt_pkg::CFG_W-1:0] cfg;
  logic                      sync_lost;
  cbt_pkg::cbt_seg_e         seg;

  wire wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire wr_cfg = wr_go && (s_axi_awaddr == cbt_pkg::CFG_OFS);
  wire wr_st  = wr_go && (s_axi_awaddr == cbt_pkg::STAT_OFS);
  wire wr_ok  = wr_cfg || wr_st;
  wire rd_go  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire rd_ok  = (s_axi_araddr == cbt_pkg::CFG_OFS) || (s_axi_araddr == cbt_pkg::STAT_OFS);
  wire lost_clr = wr_st && s_axi_wstrb[0] && s_axi_wdata[cbt_pkg::ST_LOST_POS];

  wire [31:0] cfg_word  = {{(32-cbt_pkg::CFG_W){1'b0}}, cfg};
  wire [31:0] stat_word = {28'h0000000, 2'(seg), sync_lost, bit_value_o};
  wire [31:0] rd_word   = (s_axi_araddr == cbt_pkg::CFG_OFS)  ? cfg_word :
                          (s_axi_araddr == cbt_pkg::STAT_OFS) ? stat_word : 32'h00000000;

  logic [31:0] cfg_merged;
  always_comb begin
    cfg_merged = cfg_word;
    for (int b = 0; b < 4; b++) begin
      if (s_axi_wstrb[b]) begin
        cfg_merged[8*b +: 8] = s_axi_wdata[8*b +: 8];
      end
    end
  end

  // address and data are taken together; the slave never waits on one of them
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cbt_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= cbt_pkg::RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      cfg           <= cbt_pkg::CFG_RST;
    end else if (ce_i) begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? cbt_pkg::RESP_OKAY : cbt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_cfg) begin
        cfg <= cfg_merged[cbt_pkg::CFG_W-1:0];
      end
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? cbt_pkg::RESP_OKAY : cbt_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- configuration decode ----------------
  wire       enable   = cfg[cbt_pkg::ENABLE_BIT];
  wire       triple   = cfg[cbt_pkg::TRIPLE_BIT];
  wire [3:0] sjw_len  = {2'b00, cfg[cbt_pkg::SJW_LSB +: 2]} + 4'h1;
  wire [3:0] prop_len = {1'b0, cfg[cbt_pkg::PROP_LSB +: 3]} + 4'h1;
  wire [3:0] ps1_len  = {1'b0, cfg[cbt_pkg::PS1_LSB +: 3]} + 4'h1;
  wire [3:0] ps2_fld  = {1'b0, cfg[cbt_pkg::PS2_LSB +: 3]} + 4'h1;
  // a field of one quantum is raised to the smallest legal phase 2
  wire [3:0] ps2_own  = (ps2_fld < cbt_pkg::PS2_MIN_TQ) ? cbt_pkg::PS2_MIN_TQ : ps2_fld;
  wire [3:0] ps2_der  = (ps1_len > cbt_pkg::IPT_TQ) ? ps1_len : cbt_pkg::IPT_TQ;
  wire [3:0] ps2_len  = cfg[cbt_pkg::P2SEL_BIT] ? ps2_own : ps2_der;

  // ---------------- quantum generator ----------------
  logic tq_half;
  logic tq_tick;
  logic tq_restart;

  cbt_tq_gen #(
    .PRESC_W (PRESC_W)
  ) u_tq (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .restart_i (tq_restart),
    .presc_i   (cfg[cbt_pkg::PRESC_LSB +: PRESC_W]),
    .half_o    (tq_half),
    .tick_o    (tq_tick)
  );

  // ---------------- segment sequencing ----------------
  logic [3:0] cnt;
  logic [3:0] ps1_eff;
  logic [3:0] ps2_eff;
  logic [3:0] ext;
  logic       synced;
  logic       rx_q;
  logic       last_sample;
  logic       s_full;
  logic       s_half;
  logic       pending;
  logic       bit_hold;
  logic [2:0] gap_bits;

  wire fall      = rx_q && !rx_i;
  wire edge_ok   = enable && fall && last_sample && !synced;
  wire hard_sync = edge_ok && bus_idle_i;
  wire resync    = edge_ok && !bus_idle_i;

  wire [4:0] pos_err = (seg == cbt_pkg::SEG_PROP) ? {1'b0, cnt} + 5'h01 : {1'b0, prop_len} + {1'b0, cnt} + 5'h01;
  wire [3:0] pos_adj = (pos_err > {1'b0, sjw_len}) ? sjw_len : pos_err[3:0];
  wire [3:0] neg_err = ps2_eff - cnt;
  wire in_early      = (seg == cbt_pkg::SEG_PROP) || (seg == cbt_pkg::SEG_PH1);
  wire pos_edge      = resync && in_early && !transmitting_i;
  wire neg_edge      = resync && (seg == cbt_pkg::SEG_PH2);
  wire neg_restart   = neg_edge && (neg_err <= sjw_len);
  wire neg_shorten   = neg_edge && (neg_err > sjw_len);
  wire zero_edge     = resync && (seg == cbt_pkg::SEG_SYNC);
  wire restart       = hard_sync || neg_restart;

  wire prop_end   = tq_tick && (seg == cbt_pkg::SEG_PROP) && (cnt == prop_len - 4'h1);
  wire sample_now = tq_tick && (seg == cbt_pkg::SEG_PH1) && (cnt == ps1_eff - 4'h1);
  wire ph2_end    = tq_tick && (seg == cbt_pkg::SEG_PH2) && (cnt == ps2_eff - 4'h1);
  wire ipt_done   = tq_tick && (seg == cbt_pkg::SEG_PH2) && (cnt == cbt_pkg::IPT_TQ - 4'h1);
  wire bit_start  = enable && (restart || ph2_end);
  wire deliver    = pending && (ipt_done || ph2_end || neg_restart);

  // majority of the samples one quantum early, half a quantum early and at the point
  wire vote = triple ? ((s_full & s_half) | (s_full & rx_i) | (s_half & rx_i)) : rx_i;

  assign tq_restart = !enable || restart;

  // edges pick the restart over a quantum boundary in the same clock
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      seg     <= cbt_pkg::SEG_SYNC;
      cnt     <= 4'h0;
      ps1_eff <= 4'h1;
      ps2_eff <= cbt_pkg::PS2_MIN_TQ;
      ext     <= 4'h0;
      synced  <= 1'b0;
    end else if (ce_i) begin
      if (!enable) begin
        seg     <= cbt_pkg::SEG_SYNC;
        cnt     <= 4'h0;
        ps1_eff <= ps1_len;
        ps2_eff <= ps2_len;
        ext     <= 4'h0;
        synced  <= 1'b0;
      end else if (restart) begin
        seg     <= cbt_pkg::SEG_SYNC;
        cnt     <= 4'h0;
        ps1_eff <= ps1_len;
        ps2_eff <= ps2_len;
        ext     <= 4'h0;
        synced  <= 1'b1;
      end else begin
        if (pos_edge) begin
          ps1_eff <= ps1_len + pos_adj;
          ext     <= pos_adj;
        end
        if (neg_shorten) begin
          ps2_eff <= ps2_eff - sjw_len;
        end
        if (resync || zero_edge) begin
          synced <= 1'b1;
        end
        if (tq_tick) begin
          case (seg)
            cbt_pkg::SEG_SYNC: begin
              seg <= cbt_pkg::SEG_PROP;
              cnt <= 4'h0;
            end
            cbt_pkg::SEG_PROP: begin
              seg <= prop_end ? cbt_pkg::SEG_PH1 : cbt_pkg::SEG_PROP;
              cnt <= prop_end ? 4'h0 : cnt + 4'h1;
            end
            cbt_pkg::SEG_PH1: begin
              seg <= sample_now ? cbt_pkg::SEG_PH2 : cbt_pkg::SEG_PH1;
              cnt <= sample_now ? 4'h0 : cnt + 4'h1;
            end
            cbt_pkg::SEG_PH2: begin
              if (ph2_end) begin
                seg     <= cbt_pkg::SEG_SYNC;
                cnt     <= 4'h0;
                ps1_eff <= ps1_len;
                ps2_eff <= ps2_len;
                ext     <= 4'h0;
                synced  <= 1'b0;
              end else begin
                cnt <= cnt + 4'h1;
              end
            end
            default: begin
              seg <= cbt_pkg::SEG_SYNC;
              cnt <= 4'h0;
            end
          endcase
        end
      end
    end
  end

  // ---------------- sampling, hand-over, transmit ----------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rx_q        <= 1'b1;
      s_full      <= 1'b1;
      s_half      <= 1'b1;
      last_sample <= 1'b1;
      pending     <= 1'b0;
      bit_hold    <= 1'b1;
      bit_valid_o <= 1'b0;
      bit_value_o <= 1'b1;
      tx_o        <= 1'b1;
      tx_point_o  <= 1'b0;
    end else if (ce_i) begin
      rx_q <= rx_i;
      if (tq_tick) begin
        s_full <= rx_i;
      end
      if (tq_half) begin
        s_half <= rx_i;
      end
      if (sample_now) begin
        last_sample <= vote;
        bit_hold    <= vote;
      end
      pending     <= sample_now || (pending && !deliver);
      bit_valid_o <= deliver;
      if (deliver) begin
        bit_value_o <= bit_hold;
      end
      tx_point_o <= bit_start;
      if (!enable) begin
        tx_o <= 1'b1;
      end else if (bit_start) begin
        tx_o <= tx_bit_i;
      end
    end
  end

  // bits without any falling edge on rx_i; more than six means stuffing no longer holds lock
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gap_bits  <= 3'h0;
      sync_lost <= 1'b0;
    end else if (ce_i) begin
      if (fall || bus_idle_i) begin
        gap_bits <= 3'h0;
      end else if (ph2_end && gap_bits != 3'h7) begin
        gap_bits <= gap_bits + 3'h1;
      end
      if (gap_bits > cbt_pkg::EDGE_GAP_BITS) begin
        sync_lost <= 1'b1;
      end else if (lost_clr) begin
        sync_lost <= 1'b0;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i || !ce_i);

  chk_sync_one_tq: assert property (
    (seg == cbt_pkg::SEG_SYNC && tq_tick && !restart && enable) |=> seg == cbt_pkg::SEG_PROP)
    else $error("sync segment did not last one quantum");
  chk_prop_bound: assert property (
    (enable && seg == cbt_pkg::SEG_PROP) |-> cnt < prop_len)
    else $error("propagation segment overran its length");
  chk_ps2_floor: assert property (
    ps2_len >= cbt_pkg::PS2_MIN_TQ && ps2_len <= 4'h8)
    else $error("phase 2 length out of range");
  chk_sjw_cap: assert property (
    enable |-> ext <= sjw_len && ps1_eff <= ps1_len + sjw_len)
    else $error("phase 1 lengthened beyond jump width");
  chk_hard_restart: assert property (
    hard_sync |=> seg == cbt_pkg::SEG_SYNC && cnt == 4'h0 && synced && tx_point_o)
    else $error("hard sync did not restart the bit");
  chk_tx_no_pos: assert property (
    (resync && in_early && transmitting_i) |=> ps1_eff == $past(ps1_eff))
    else $error("transmitter resynchronised on positive error");
  chk_one_sync: assert property (
    (enable && synced && fall && seg != cbt_pkg::SEG_SYNC && !tq_tick) |=> $stable(seg) && $stable(ps1_eff))
    else $error("second synchronisation within one bit");
  chk_ipt_handover: assert property (
    sample_now |-> !bit_valid_o ##1 pending ##1 !bit_valid_o)
    else $error("bit handed over before processing time");
  chk_ps2_derive: assert property (
    !cfg[cbt_pkg::P2SEL_BIT] |-> ps2_len >= ps1_len && ps2_len >= cbt_pkg::IPT_TQ)
    else $error("derived phase 2 too short");
  chk_tx_launch: assert property (
    (bit_start && enable) |=> tx_point_o && tx_o == $past(tx_bit_i))
    else $error("transmit bit not launched at bit start");

  cov_hard_sync:   cover property (hard_sync);
  cov_pos_resync:  cover property (pos_edge && pos_err > sjw_len);
  cov_neg_restart: cover property (neg_restart);
  cov_triple_vote: cover property (sample_now && triple && s_full != rx_i);

endmodule

// ---- cbt_pkg.sv ----
// cbt_pkg: shared constants of the CAN bit timing block
// assumes a single 125 MHz clock domain and a 32-bit AXI4-Lite register bus
package cbt_pkg;

  // register byte offsets
  localparam logic [3:0] CFG_OFS  = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;

  // timing configuration register field positions
  localparam int PRESC_LSB  = 0;
  localparam int SJW_LSB    = 6;
  localparam int PROP_LSB   = 8;
  localparam int PS1_LSB    = 11;
  localparam int PS2_LSB    = 14;
  localparam int P2SEL_BIT  = 17;
  localparam int TRIPLE_BIT = 18;
  localparam int ENABLE_BIT = 19;
  localparam int CFG_W      = 20;
  localparam logic [CFG_W-1:0] CFG_RST = 20'h00000;

  // status register field positions
  localparam int ST_BIT_POS  = 0;
  localparam int ST_LOST_POS = 1;
  localparam int ST_SEG_LSB  = 2;

  // fixed timing figures in time quanta; the edge gap limit in bits
  localparam logic [3:0] SYNC_TQ    = 4'h1;
  localparam logic [3:0] IPT_TQ     = 4'h2;
  localparam logic [3:0] PS2_MIN_TQ = 4'h2;
  localparam logic [2:0] EDGE_GAP_BITS = 3'h6;

  // axi answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} cbt_seg_e;

endpackage

// ---- cbt_tq_gen.sv ----
// cbt_tq_gen: time quantum generator, one quantum is 2*(prescaler+1) clocks
// assumes the prescaler value only changes while the timing logic is disabled
`timescale 1ns/1ps
module cbt_tq_gen #(
  parameter int PRESC_W = 6
) (
  // clock and control
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire logic               ce_i,
  input  wire logic               restart_i,
  input  wire logic [PRESC_W-1:0] presc_i,
  // quantum strobes
  output logic                    half_o,
  output logic                    tick_o
);

  generate
    if (PRESC_W < 1 || PRESC_W > 16) begin : g_bad
      $error("cbt_tq_gen: PRESC_W out of range");
    end
  endgenerate

  logic [PRESC_W:0] cnt;
  logic [PRESC_W:0] next_cnt;
  wire  [PRESC_W:0] half_pt = {1'b0, presc_i};
  wire  [PRESC_W:0] last_pt = {presc_i, 1'b1};
  wire              at_last = (cnt == last_pt);

  assign next_cnt = (restart_i || at_last) ? '0 : cnt + 1'b1;

  // restart puts the quantum boundary at the edge that caused it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt    <= '0;
      half_o <= 1'b0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      cnt    <= next_cnt;
      half_o <= !restart_i && (next_cnt == half_pt);
      tick_o <= !restart_i && (next_cnt == last_pt);
    end
  end

endmodule

// ---- cbt_bus_node.sv ----
// cbt_bus_node: another node on the can bus sending one 16-bit frame
// assumes the bench wire-ands rx_o with the device drive; bus idles recessive
`timescale 1ns/1ps
module cbt_bus_node (
  // clock and frame request
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [15:0] pattern_i,
  input  wire logic [15:0] bit_clks_i,
  // bus drive
  output logic             rx_o,
  output logic             busy_o
);
  logic [15:0] sh = 16'h0000;
  logic [15:0] cnt = 16'h0000;
  logic [4:0]  left = 5'h00;
  initial rx_o = 1'b1;
  initial busy_o = 1'b0;
  // the pattern carries its own falling edges, as stuffing would
  always @(posedge clk_i) begin
    if (go_i && !busy_o) begin
      sh <= pattern_i;
      rx_o <= pattern_i[15];
      left <= 5'h10;
      cnt <= 16'h0000;
      busy_o <= 1'b1;
    end else if (busy_o) begin
      if (cnt == bit_clks_i - 16'h0001) begin
        cnt <= 16'h0000;
        sh <= sh << 1;
        left <= left - 5'h01;
        // released bus returns to the recessive pull-up level
        rx_o <= (left == 5'h01) ? 1'b1 : sh[14];
        busy_o <= (left != 5'h01);
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule

// ---- tb.sv ----
// tb: self-checking bench for the can bit timing block
// assumes cbt_pkg, cbt_bit_timing and cbt_bus_node are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic [3:0]  araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        tx_bit = 1'b1, transmitting = 1'b0, bus_idle = 1'b1, go = 1'b0, tx_chk = 1'b0, ce = 1'b1;
  logic [3:0]  frz = 4'h0;
  int          frz_bad = 0;
  logic [15:0] pattern = 16'h0000;
  logic [15:0] bit_clks = 16'h0001;
  wire         awready, wready, bvalid, arready, rvalid, node_rx, node_busy;
  wire         tx_o, tx_point, bit_valid, bit_value;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire         rx_i = node_rx & tx_o;
  int          fail_count = 0, compares = 0, cnt = 0, last_per = 0, bvc = 0, last_bv = 0;
  logic        got[$];
  int          tbl[5][6] = '{'{0, 1, 1, 2, 1, 10}, '{3, 8, 8, 8, 1, 200}, '{0, 2, 5, 3, 0, 26},
                             '{0, 3, 1, 8, 0, 14}, '{63, 1, 1, 2, 1, 640}};
  int          nclk[5] = '{44, 45, 43, 44, 45};
  const logic [1:0] OK = cbt_pkg::RESP_OKAY;
  const logic [1:0] ERR = cbt_pkg::RESP_SLVERR;

  always #4 clk_i = ~clk_i;

  cbt_bit_timing #(.PRESC_W(6)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_i(rx_i), .tx_o(tx_o), .tx_bit_i(tx_bit), .transmitting_i(transmitting),
    .bus_idle_i(bus_idle), .tx_point_o(tx_point), .bit_valid_o(bit_valid), .bit_value_o(bit_value));

  cbt_bus_node node (.clk_i(clk_i), .go_i(go), .pattern_i(pattern), .bit_clks_i(bit_clks),
    .rx_o(node_rx), .busy_o(node_busy));

  // bit length and decided-bit count per bit, measured between bit starts
  always @(posedge clk_i) begin
    if (bit_valid) got.push_back(bit_value);
    if (tx_point) begin
      last_per <= cnt;
      last_bv <= bvc + int'(bit_valid);
      cnt <= 1;
      bvc <= 0;
      if (tx_chk) begin
        `CHK(tx_o, tx_bit)
        tx_bit <= ~tx_bit;
      end
    end else begin
      cnt <= cnt + 1;
      bvc <= bvc + int'(bit_valid);
    end
  end

  task automatic conclude();
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic timed_out();
    fail_count++;
    $display("[ERR] %0t wait timed out", $time);
    conclude();
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (i == 50) timed_out();
    `CHK(bresp, er)
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [3:0] a, input logic [31:0] e, m, input logic [1:0] er);
    int i;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 50) timed_out();
    `CHK(rdata & m, e)
    `CHK(rresp, er)
    rready <= 1'b0;
  endtask

  task automatic wait_bits(input int n);
    int lim;
    lim = 3000 * n;
    for (int i = 0; i < lim && n > 0; i++) begin
      @(posedge clk_i);
      if (tx_point === 1'b1) n--;
    end
    if (n > 0) timed_out();
  endtask

  function automatic logic [31:0] mk(input int p, sjw, prop, ps1, ps2, sel, trip);
    return 32'(p) | 32'((sjw - 1) << cbt_pkg::SJW_LSB) | 32'((prop - 1) << cbt_pkg::PROP_LSB)
      | 32'((ps1 - 1) << cbt_pkg::PS1_LSB) | 32'((ps2 - 1) << cbt_pkg::PS2_LSB)
      | 32'(sel << cbt_pkg::P2SEL_BIT) | 32'(trip << cbt_pkg::TRIPLE_BIT)
      | (32'h1 << cbt_pkg::ENABLE_BIT);
  endfunction

  // prescaler may only change while disabled, so every setting passes through zero
  task automatic configure(input logic [31:0] c);
    axi_write(4'(cbt_pkg::CFG_OFS), 32'h0, OK);
    axi_write(4'(cbt_pkg::CFG_OFS), c, OK);
    axi_read(4'(cbt_pkg::CFG_OFS), c, 32'hFFFFFFFF, OK);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    axi_read(4'(cbt_pkg::CFG_OFS), 32'h0, 32'hFFFFFFFF, OK);
    axi_read(4'(cbt_pkg::STAT_OFS), 32'h1, 32'hF, OK);
    `CHK(tx_o, 1'b1)
    `CHK(bit_valid, 1'b0)
    axi_read(4'h8, 32'h0, 32'hFFFFFFFF, ERR);
    axi_write(4'hC, 32'hFFFFFFFF, ERR);
    axi_read(4'(cbt_pkg::CFG_OFS), 32'h0, 32'hFFFFFFFF, OK);
    for (int i = 0; i < 5; i++) begin
      configure(mk(tbl[i][0], 1, tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4], 0));
      wait_bits(3);
      `CHK(last_per, tbl[i][5])
      `CHK(last_bv, 1)
    end
    // frames from a node whose clock runs on time, slightly fast or slightly slow
    // the last frame is received while transmitting, so a late edge must not lengthen phase 1
    for (int i = 0; i < 5; i++) begin
      configure(mk(1, (i < 2) ? 1 : 4, 2, 3, 5, 1, i % 2));
      bus_idle <= 1'b1;
      transmitting <= (i == 4);
      wait_bits(2);
      got.delete();
      pattern <= 16'h2C9B;
      bit_clks <= 16'(nclk[i]);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      wait_bits(1);
      bus_idle <= 1'b0;
      wait_bits(17);
      while (got.size() > 0 && got[0] === 1'b1) got.pop_front();
      for (int k = 0; k < 16; k++) `CHK(got[k], pattern[15 - k])
      `CHK(node_busy, 1'b0)
    end
    configure(mk(0, 1, 1, 1, 2, 1, 0));
    wait_bits(8);
    axi_read(4'(cbt_pkg::STAT_OFS), 32'h2, 32'h2, OK);
    bus_idle <= 1'b1;
    wait_bits(1);
    axi_write(4'(cbt_pkg::STAT_OFS), 32'h2, OK);
    axi_read(4'(cbt_pkg::STAT_OFS), 32'h0, 32'h2, OK);
    transmitting <= 1'b1;
    bus_idle <= 1'b0;
    tx_chk <= 1'b1;
    wait_bits(6);
    tx_chk <= 1'b0;
    wait_bits(1);
    transmitting <= 1'b0;
    wait_bits(1);
    // clock enable low must freeze tx_o, tx_point, bit_valid and bit_value of the block
    ce <= 1'b0;
    @(posedge clk_i);
    frz = {tx_o, tx_point, bit_valid, bit_value};
    repeat (60) @(posedge clk_i) if ({tx_o, tx_point, bit_valid, bit_value} !== frz) frz_bad++;
    `CHK(frz_bad, 0)
    ce <= 1'b1;
    wait_bits(2);
    conclude();
  end
endmodule
